/* File: logic/jtr_top.sv */
// Purpose: Test access port with boundary scan and register access
// Assumes: Test pins sampled by the 20 MHz core clock, TCK much slower
// Notes: High-speed serial pins are not part of the boundary chain
`timescale 1ns/10ps
`default_nettype none
module jtr_top (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic trstn_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] core_out_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe_out,
  input wire logic [20:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out
);
  typedef enum logic [3:0] {
    ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
  } jtr_state_t;

  jtr_state_t st_q, st_d;
  logic [3:0] pin_s, pad_s;
  logic tck_s, tms_s, tdi_s, trstn_s, tck_p_q, rise, fall;
  logic [2:0] ir_q, ir_d, irs_q, irs_d;
  logic byp_q, byp_d;
  logic [31:0] ids_q, ids_d;
  logic [7:0] bsr_q, bsr_d, bup_q, bup_d;
  logic [112:0] acc_q, acc_d;
  logic tdo_d, oe_d;
  logic [3:0] pout_d, poe_d;
  logic req_q, req_d, rdy_q, rdy_d, err_q, err_d, rw_q, rw_d;
  logic [20:0] ra_q, ra_d;
  logic [31:0] rd_q, rd_d;
  logic done_w, derr_w;
  logic [31:0] drd_w;
  logic [20:0] acc_addr_w;

  // Pins come from the test clock side, two stages each
  jtr_sync #(.W(4), .RST(4'h8)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .async_in({trstn_in, tdi_in, tms_in, tck_in}),
    .sync_out(pin_s)
  );
  jtr_sync #(.W(4), .RST(4'h0)) u_pad_sync (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .async_in(pad_in),
    .sync_out(pad_s)
  );
  assign {trstn_s, tdi_s, tms_s, tck_s} = pin_s;
  assign rise = tck_s && !tck_p_q;
  assign fall = !tck_s && tck_p_q;
  assign acc_addr_w = acc_q[jtr_pkg::ADDR_HI:jtr_pkg::ADDR_LO];

  // Register map shared with software
  jtr_regfile u_regs (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .jreq_in(req_q),
    .jaddr_in(ra_q),
    .jrw_in(rw_q),
    .jwdata_in(rd_q),
    .jdone_out(done_w),
    .jerr_out(derr_w),
    .jrdata_out(drd_w)
  );

  // Standard TAP walk on each sampled TCK rise
  always_comb begin
    st_d = st_q;
    if (!trstn_s) begin
      st_d = ST_TLR;
    end else if (rise) begin
      case (st_q)
        ST_TLR: st_d = tms_s ? ST_TLR : ST_RTI;
        ST_RTI: st_d = tms_s ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: st_d = tms_s ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_d = tms_s ? ST_UP_DR : ST_PA_DR;
        ST_PA_DR: st_d = tms_s ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: st_d = tms_s ? ST_UP_DR : ST_SH_DR;
        ST_UP_DR: st_d = tms_s ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: st_d = tms_s ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: st_d = tms_s ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_d = tms_s ? ST_UP_IR : ST_PA_IR;
        ST_PA_IR: st_d = tms_s ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: st_d = tms_s ? ST_UP_IR : ST_SH_IR;
        ST_UP_IR: st_d = tms_s ? ST_SEL_DR : ST_RTI;
        default: st_d = ST_TLR;
      endcase
    end
  end

  // Instruction and data registers, shifted LSB first
  always_comb begin
    ir_d = ir_q;
    irs_d = irs_q;
    byp_d = byp_q;
    ids_d = ids_q;
    bsr_d = bsr_q;
    bup_d = bup_q;
    acc_d = acc_q;
    if (st_q == ST_TLR) begin
      ir_d = jtr_pkg::OP_IDCODE;
    end else if (rise) begin
      case (st_q)
        ST_CAP_IR: irs_d = jtr_pkg::IR_CAPTURE;
        ST_SH_IR: irs_d = {tdi_s, irs_q[2:1]};
        ST_UP_IR: ir_d = irs_q;
        ST_CAP_DR: begin
          byp_d = 1'b0;
          ids_d = jtr_pkg::IDCODE_VAL;
          bsr_d = {core_out_in, pad_s};
          // Last result, data only meaningful after a read
          acc_d = {{jtr_pkg::RSV_W{1'b0}}, ra_q, rw_q, rd_q,
                   err_q, rdy_q};
        end
        ST_SH_DR: begin
          case (ir_q)
            jtr_pkg::OP_IDCODE: ids_d = {tdi_s, ids_q[31:1]};
            jtr_pkg::OP_EXTEST, jtr_pkg::OP_SAMPLE:
              bsr_d = {tdi_s, bsr_q[7:1]};
            jtr_pkg::OP_REG_ACCESS:
              acc_d = {tdi_s, acc_q[112:1]};
            default: byp_d = tdi_s;
          endcase
        end
        ST_UP_DR: begin
          if (ir_q == jtr_pkg::OP_EXTEST || ir_q == jtr_pkg::OP_SAMPLE) begin
            bup_d = bsr_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Request launch at Update-DR, completion back from register side
  always_comb begin
    req_d = 1'b0;
    ra_d = ra_q;
    rw_d = rw_q;
    rd_d = rd_q;
    rdy_d = rdy_q;
    err_d = err_q;
    if (rise && st_q == ST_UP_DR && ir_q == jtr_pkg::OP_REG_ACCESS) begin
      req_d = 1'b1;
      ra_d = acc_addr_w;
      rw_d = acc_q[jtr_pkg::RW_BIT];
      rd_d = acc_q[jtr_pkg::DATA_HI:jtr_pkg::DATA_LO];
      rdy_d = 1'b0;
      err_d = 1'b0;
    end
    // Completion wins over a launch in the same cycle
    if (done_w) begin
      rdy_d = 1'b1;
      err_d = derr_w;
      rd_d = rw_q ? rd_q : drd_w;
    end
  end

  // TDO moves on the falling TCK edge, enabled only while shifting
  always_comb begin
    tdo_d = tdo_out;
    oe_d = tdo_oe_out;
    if (fall) begin
      oe_d = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
      if (st_q == ST_SH_IR) begin
        tdo_d = irs_q[0];
      end else begin
        case (ir_q)
          jtr_pkg::OP_IDCODE: tdo_d = ids_q[0];
          jtr_pkg::OP_EXTEST, jtr_pkg::OP_SAMPLE: tdo_d = bsr_q[0];
          jtr_pkg::OP_REG_ACCESS: tdo_d = acc_q[0];
          default: tdo_d = byp_q;
        endcase
      end
    end
  end

  // Pad drive: extest and clamp use update cells, high-Z floats all
  always_comb begin
    pout_d = core_out_in;
    poe_d = 4'hf;
    if (ir_q == jtr_pkg::OP_EXTEST || ir_q == jtr_pkg::OP_CLAMP) begin
      pout_d = bup_q[7:4];
    end
    if (ir_q == jtr_pkg::OP_HIGHZ) begin
      poe_d = 4'h0;
    end
  end

  // All state registered here; instruction kept until changed
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_TLR;
      tck_p_q <= 1'b0;
      ir_q <= jtr_pkg::OP_IDCODE;
      irs_q <= 3'h0;
      byp_q <= 1'b0;
      ids_q <= 32'h0;
      bsr_q <= 8'h00;
      bup_q <= 8'h00;
      acc_q <= '0;
      req_q <= 1'b0;
      ra_q <= 21'h0;
      rw_q <= 1'b0;
      rd_q <= 32'h0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
      pad_out <= 4'h0;
      pad_oe_out <= 4'h0;
    end else begin
      st_q <= st_d;
      tck_p_q <= tck_s;
      ir_q <= ir_d;
      irs_q <= irs_d;
      byp_q <= byp_d;
      ids_q <= ids_d;
      bsr_q <= bsr_d;
      bup_q <= bup_d;
      acc_q <= acc_d;
      req_q <= req_d;
      ra_q <= ra_d;
      rw_q <= rw_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      tdo_out <= tdo_d;
      tdo_oe_out <= oe_d;
      pad_out <= pout_d;
      pad_oe_out <= poe_d;
    end
  end

  AST_TRST_TLR: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) !trstn_s |=> st_q == ST_TLR)
    else $error("test reset did not force reset state");
  AST_TLR_IDCODE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    st_q == ST_TLR && $past(st_q) == ST_TLR |-> ir_q == jtr_pkg::OP_IDCODE)
    else $error("reset state lacks id instruction");
  AST_ID_CAPTURE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rise && st_q == ST_CAP_DR |=> ids_q == jtr_pkg::IDCODE_VAL)
    else $error("id register not loaded");
  AST_REQ_PULSE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rise && st_q == ST_UP_DR && ir_q == jtr_pkg::OP_REG_ACCESS |=>
    req_q ##1 !req_q)
    else $error("access request not a single pulse");
  AST_REQ_FIELDS: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    req_q |-> ra_q == $past(acc_addr_w) && !rdy_q)
    else $error("request address not taken from register");
  AST_DONE_BOUND: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) req_q |-> ##[1:4] rdy_q)
    else $error("access did not complete");
  AST_CAP_STATUS: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rise && st_q == ST_CAP_DR && ir_q == jtr_pkg::OP_REG_ACCESS |=>
    acc_q[jtr_pkg::RDY_BIT] == $past(rdy_q) &&
    acc_q[jtr_pkg::ERR_BIT] == $past(err_q))
    else $error("ready and error not captured");
  AST_HIGHZ: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    (ir_q == jtr_pkg::OP_HIGHZ) [*2] |-> pad_oe_out == 4'h0)
    else $error("pads driven under high-Z");
  AST_TDO_OE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    $rose(tdo_oe_out) |-> $past(st_q) == ST_SH_DR || $past(st_q) == ST_SH_IR)
    else $error("tdo enabled outside shift");
endmodule
`default_nettype wire

/* File: logic/jtr_pkg.sv */
// Purpose: Shared constants for the test port register access block
// Assumes: 20 MHz core clock, test clock sampled by it
// Notes: Opcodes outside the register access code are house values
package jtr_pkg;
  // Instruction register
  localparam int IR_W = 3;
  localparam logic [2:0] OP_EXTEST = 3'h0;
  localparam logic [2:0] OP_SAMPLE = 3'h1;
  localparam logic [2:0] OP_IDCODE = 3'h2;
  localparam logic [2:0] OP_HIGHZ = 3'h3;
  localparam logic [2:0] OP_CLAMP = 3'h4;
  localparam logic [2:0] OP_REG_ACCESS = 3'h5;
  localparam logic [2:0] OP_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // Identification value, arbitrary, bit 0 must be one
  localparam logic [31:0] IDCODE_VAL = 32'h0a5c_3001;
  // Register access data register layout
  localparam int ACC_W = 113;
  localparam int RSV_W = 57;
  localparam int ADDR_HI = 55;
  localparam int ADDR_LO = 35;
  localparam int RW_BIT = 34;
  localparam int DATA_HI = 33;
  localparam int DATA_LO = 2;
  localparam int ERR_BIT = 1;
  localparam int RDY_BIT = 0;
  localparam int ADDR_W = 21;
  // Boundary chain: input cells then output cells
  localparam int PAD_N = 4;
  localparam int BSR_W = 8;
  // Register map, byte offsets
  localparam logic [20:0] OFS_CTRL = 21'h000000;
  localparam logic [20:0] OFS_STAT = 21'h000004;
  localparam logic [20:0] OFS_SCR0 = 21'h000010;
  localparam int SCR_N = 4;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_ERR_BIT = 8;
  // Register selector codes
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_STAT = 3'h1;
  localparam logic [2:0] SEL_SCR = 3'h2;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // Timing
  localparam int CORE_HZ = 20000000;
  localparam int MIN_IDLE_TCK = 20;
endpackage

/* File: logic/jtr_sync.sv */
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are levels from outside the core clock
// Notes: Only the second stage may be read
`timescale 1ns/10ps
`default_nettype none
module jtr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // Metastability chain
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RST;
      sync_out <= RST;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: logic/jtr_regfile.sv */
// Purpose: Configuration registers, Avalon slave plus test port access
// Assumes: One test port request at a time, spaced far apart
// Notes: Avalon access waits at most one test port request
`timescale 1ns/10ps
`default_nettype none
module jtr_regfile (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [20:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic jreq_in,
  input wire logic [20:0] jaddr_in,
  input wire logic jrw_in,
  input wire logic [31:0] jwdata_in,
  output logic jdone_out,
  output logic jerr_out,
  output logic [31:0] jrdata_out
);
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] scr_q [jtr_pkg::SCR_N];
  logic [31:0] scr_d [jtr_pkg::SCR_N];
  logic [7:0] cnt_q, cnt_d;
  logic lerr_q, lerr_d, jp_q, jp_d, wait_d, done_d, err_d;
  logic [31:0] rd_d, jrd_d;
  logic [20:0] pa_q, pa_d;
  logic prw_q, prw_d;
  logic [31:0] pwd_q, pwd_d;

  // Same offsets for both masters, unmapped gives none
  function automatic logic [2:0] reg_sel(input logic [20:0] a);
    if (a == jtr_pkg::OFS_CTRL) begin
      return jtr_pkg::SEL_CTRL;
    end else if (a == jtr_pkg::OFS_STAT) begin
      return jtr_pkg::SEL_STAT;
    end else if (a >= jtr_pkg::OFS_SCR0 && a[1:0] == 2'h0 &&
                 a < jtr_pkg::OFS_SCR0 + 21'(4 * jtr_pkg::SCR_N)) begin
      return jtr_pkg::SEL_SCR;
    end else begin
      return jtr_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] rd_val(input logic [20:0] a,
    input logic [31:0] c, input logic [31:0] s, input logic [7:0] n,
    input logic e);
    case (reg_sel(a))
      jtr_pkg::SEL_CTRL: return c;
      jtr_pkg::SEL_STAT: return {23'h0, e, n};
      jtr_pkg::SEL_SCR: return s;
      default: return 32'h0;
    endcase
  endfunction

  // Arbiter and register update, test port request first
  always_comb begin
    logic [1:0] ai;
    logic [1:0] ji;
    ai = 2'(avs_address_in[20:2] - jtr_pkg::OFS_SCR0[20:2]);
    ji = 2'(pa_q[20:2] - jtr_pkg::OFS_SCR0[20:2]);
    ctrl_d = ctrl_q;
    scr_d = scr_q;
    cnt_d = cnt_q;
    lerr_d = lerr_q;
    jp_d = jp_q | jreq_in;
    pa_d = jreq_in ? jaddr_in : pa_q;
    prw_d = jreq_in ? jrw_in : prw_q;
    pwd_d = jreq_in ? jwdata_in : pwd_q;
    wait_d = 1'b1;
    done_d = 1'b0;
    err_d = jerr_out;
    rd_d = avs_readdata_out;
    jrd_d = jrdata_out;
    if (jp_q) begin
      // Offset is taken from the normal register map
      jp_d = jreq_in;
      done_d = 1'b1;
      err_d = !ctrl_q[jtr_pkg::CTRL_EN_BIT] ||
              reg_sel(pa_q) == jtr_pkg::SEL_NONE ||
              (prw_q && reg_sel(pa_q) == jtr_pkg::SEL_STAT);
      if (!err_d && prw_q) begin
        if (reg_sel(pa_q) == jtr_pkg::SEL_CTRL) begin
          ctrl_d = pwd_q;
        end else begin
          scr_d[ji] = pwd_q;
        end
      end
      jrd_d = (err_d || prw_q) ? 32'h0 :
              rd_val(pa_q, ctrl_q, scr_q[ji], cnt_q, lerr_q);
      cnt_d = cnt_q + 8'h01;
      lerr_d = err_d;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      wait_d = 1'b0;
      rd_d = rd_val(avs_address_in, ctrl_q, scr_q[ai], cnt_q, lerr_q);
      if (avs_write_in) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable_in[b]) begin
            if (reg_sel(avs_address_in) == jtr_pkg::SEL_CTRL) begin
              ctrl_d[8*b +: 8] = avs_writedata_in[8*b +: 8];
            end else if (reg_sel(avs_address_in) == jtr_pkg::SEL_SCR) begin
              scr_d[ai][8*b +: 8] = avs_writedata_in[8*b +: 8];
            end
          end
        end
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= jtr_pkg::CTRL_RST;
      for (int i = 0; i < jtr_pkg::SCR_N; i++) begin
        scr_q[i] <= 32'h0;
      end
      cnt_q <= 8'h00;
      lerr_q <= 1'b0;
      jp_q <= 1'b0;
      pa_q <= 21'h0;
      prw_q <= 1'b0;
      pwd_q <= 32'h0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0;
      jdone_out <= 1'b0;
      jerr_out <= 1'b0;
      jrdata_out <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      scr_q <= scr_d;
      cnt_q <= cnt_d;
      lerr_q <= lerr_d;
      jp_q <= jp_d;
      pa_q <= pa_d;
      prw_q <= prw_d;
      pwd_q <= pwd_d;
      avs_waitrequest_out <= wait_d;
      avs_readdata_out <= rd_d;
      jdone_out <= done_d;
      jerr_out <= err_d;
      jrdata_out <= jrd_d;
    end
  end

  // Avalon answer within a bounded wait
  AST_AV_ANSWER: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    (avs_read_in || avs_write_in) && avs_waitrequest_out |->
    ##[1:3] !avs_waitrequest_out)
    else $error("avalon access not answered");
  // Test port request completes promptly
  AST_J_DONE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    jreq_in |-> ##[2:3] jdone_out)
    else $error("test port access not completed");
endmodule
`default_nettype wire

/* File: sim/jtr_jtag_host.sv */
// Purpose: Behavioural test-port host driving four test pins and reading TDO
// Assumes: 400 ns test clock, parked low between frames
// Notes: TDI parks high, as the pulled-up line would
`timescale 1ns/10ps
`default_nettype none
module jtr_jtag_host (
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trstn_out
);
  // Pins idle, TCK stands still until a frame
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trstn_out = 1'b1;
  end
  // One test clock, edges kept off the core clock edges
  // TDO taken just before the rise; period stays 400 ns
  task automatic step(input logic m, input logic d, output logic o);
    #5;
    tms_out = m;
    tdi_out = d;
    #200;
    o = tdo_in;
    tck_out = 1'b1;
    #190;
    tck_out = 1'b0;
    tdi_out = 1'b1;
    #5;
  endtask
  // Walk a short TMS pattern, LSB first
  task automatic walk(input logic [3:0] p, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(p[i], 1'b1, o);
    end
  endtask
  // Stay in Run-Test/Idle for n clocks
  task automatic idle(input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(1'b0, 1'b1, o);
    end
  endtask
  // Pulse test reset, end in Run-Test/Idle
  task automatic tap_reset();
    #5;
    trstn_out = 1'b0;
    #1000;
    trstn_out = 1'b1;
    #395;
    walk(4'h0, 1);
  endtask
  // Shift n bits LSB first, from and back to Run-Test/Idle
  task automatic shift(input logic ir, input logic [112:0] din,
                       input int n, output logic [112:0] dout);
    logic o;
    dout = '0;
    walk(ir ? 4'h3 : 4'h1, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(4'h1, 2);
  endtask
endmodule
`default_nettype wire

/* File: sim/jtr_top_bench.sv */
// Purpose: Self-checking bench for the test port register access block
// Assumes: Host model drives the test pins, bench is the Avalon master
// Notes: Pad inputs, core outputs and byte lanes are held constant
`timescale 1ns/10ps
`default_nettype none
module jtr_top_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic tck, tms, tdi, trstn, tdo, tdo_oe;
  logic [3:0] pad_out, pad_oe;
  logic [20:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [112:0] r;
  logic [31:0] q;
  int n_mismatch = 0;
  int num_checks = 0;
  jtr_top u_jtr_top (.core_clk_in(core_clk), .rstn_in(rstn),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .trstn_in(trstn),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pad_in(4'h6),
    .core_out_in(4'h9), .pad_out(pad_out), .pad_oe_out(pad_oe),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest));
  // Pulled-up TDO line: host sees one while the port floats
  jtr_jtag_host u_jtr_jtag_host (.tdo_in(tdo_oe ? tdo : 1'b1), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trstn_out(trstn));
  // 20 MHz core clock
  always #25 core_clk = ~core_clk;
  // Verdict, reached from the end or a stuck wait
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [112:0] e,
                     input logic [112:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Avalon access held until waitrequest is seen low
  task automatic av(input logic w, input logic [20:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // Request shift, 20 idle clocks, finishing shift of zeros
  task automatic jacc(input logic [20:0] a, input logic rw,
                      input logic [31:0] d, output logic [112:0] res);
    logic [112:0] t;
    u_jtr_jtag_host.shift(1'b0, {57'h0, a, rw, d, 2'b00}, 113, t);
    u_jtr_jtag_host.idle(20);
    u_jtr_jtag_host.shift(1'b0, 113'h0, 113, res);
  endtask
  task automatic t_reset();
    repeat (4) @(posedge core_clk);
    chk("pad_oe", 4'hf, pad_oe);
    chk("pad_out", 4'h9, pad_out);
    chk("waitrequest", 1'b1, avs_waitrequest);
  endtask
  task automatic t_idcode();
    u_jtr_jtag_host.tap_reset();
    u_jtr_jtag_host.shift(1'b0, 113'h0, 32, r);
    chk("idcode", jtr_pkg::IDCODE_VAL, r[31:0]);
  endtask
  task automatic t_jwrite();
    u_jtr_jtag_host.shift(1'b1, 113'h5, 3, r);
    chk("ir_capture", jtr_pkg::IR_CAPTURE, r[2:0]);
    jacc(jtr_pkg::OFS_SCR0, 1'b1, 32'hc3a5_1e0f, r);
    chk("wr_status", 2'b01, r[1:0]);
    av(1'b0, jtr_pkg::OFS_SCR0, 32'h0, q);
    chk("scr0", 32'hc3a5_1e0f, q);
  endtask
  task automatic t_jread();
    av(1'b1, 21'h000014, 32'h5a6b_7c8d, q);
    jacc(21'h000014, 1'b0, 32'h0, r);
    chk("rd_status", 2'b01, r[1:0]);
    chk("rd_data", 32'h5a6b_7c8d, r[33:2]);
    chk("rd_addr", 21'h000014, r[55:35]);
  endtask
  // Status read before the finishing shift, which is itself an access
  task automatic t_jerr();
    u_jtr_jtag_host.shift(1'b0, {57'h0, jtr_pkg::OFS_STAT, 1'b1,
                          32'hffff_ffff, 2'b00}, 113, r);
    u_jtr_jtag_host.idle(20);
    av(1'b0, jtr_pkg::OFS_STAT, 32'h0, q);
    chk("stat_err", 1'b1, q[jtr_pkg::STAT_ERR_BIT]);
    chk("stat_count", 8'h05, q[7:0]);
    u_jtr_jtag_host.shift(1'b0, 113'h0, 113, r);
    chk("err_status", 2'b11, r[1:0]);
    av(1'b0, 21'h000100, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  // Sample loads update cells, extest and clamp drive them out
  task automatic t_bscan();
    u_jtr_jtag_host.shift(1'b1, 113'h1, 3, r);
    u_jtr_jtag_host.shift(1'b0, 113'h50, 8, r);
    chk("bsr_capture", 8'h96, r[7:0]);
    u_jtr_jtag_host.shift(1'b1, 113'h0, 3, r);
    u_jtr_jtag_host.idle(2);
    chk("extest_out", 4'h5, pad_out);
    u_jtr_jtag_host.shift(1'b1, 113'h4, 3, r);
    u_jtr_jtag_host.idle(2);
    chk("clamp_out", 4'h5, pad_out);
    chk("clamp_oe", 4'hf, pad_oe);
  endtask
  task automatic t_modes();
    u_jtr_jtag_host.shift(1'b1, 113'h3, 3, r);
    u_jtr_jtag_host.idle(2);
    chk("highz_oe", 4'h0, pad_oe);
    u_jtr_jtag_host.shift(1'b1, 113'h7, 3, r);
    u_jtr_jtag_host.shift(1'b0, 113'hb5, 8, r);
    chk("bypass", 8'h6a, r[7:0]);
    chk("bypass_oe", 4'hf, pad_oe);
    chk("tdo_idle_oe", 1'b0, tdo_oe);
    u_jtr_jtag_host.tap_reset();
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_idcode();
    t_jwrite();
    t_jread();
    t_jerr();
    t_bscan();
    t_modes();
    wrap_up();
  end
endmodule
`default_nettype wire
